// >>> rtl/scsr_pkg.sv
package scsr_pkg;
    // =========================================
    // serial word layout
    localparam int WORD_W   = 16;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 12;
    localparam int NUM_REGS = 16;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] WORD_BITS = 5'h10;

    // =========================================
    // register addresses
    localparam logic [ADDR_W-1:0] A_SEQUENCER     = 4'h0;
    localparam logic [ADDR_W-1:0] A_SECOND_SLOPE  = 4'h5;
    localparam logic [ADDR_W-1:0] A_THIRD_SLOPE   = 4'h6;
    localparam logic [ADDR_W-1:0] A_CHARGE_XFER   = 4'h7;
    localparam logic [ADDR_W-1:0] A_CAL_DAC       = 4'h8;
    localparam logic [ADDR_W-1:0] A_BLACK_DAC     = 4'h9;
    localparam logic [ADDR_W-1:0] A_OFFSET_DAC    = 4'hA;
    localparam logic [ADDR_W-1:0] A_INPUT_ROUTING = 4'hB;
    localparam logic [ADDR_W-1:0] A_AMP_GAIN      = 4'hC;
    localparam logic [ADDR_W-1:0] A_CALIB_LOW     = 4'hD;
    localparam logic [ADDR_W-1:0] A_CALIB_MID     = 4'hE;
    localparam logic [ADDR_W-1:0] A_CALIB_HIGH    = 4'hF;

    // =========================================
    // reset values, indexed by address
    localparam logic [DATA_W-1:0] REG_DEFAULT [NUM_REGS] = '{
        12'h029, 12'h000, 12'h000, 12'h0A0,
        12'h002, 12'h000, 12'h000, 12'h1E1,
        12'h04A, 12'h06B, 12'h055, 12'h0F0,
        12'hFB0, 12'hADF, 12'h6DB, 12'h0DB
    };

    // =========================================
    // field positions
    localparam int SQ_MASTER    = 0;
    localparam int SQ_SUBSAMPLE = 1;
    localparam int SQ_GRAN_LO   = 2;
    localparam int SQ_SS_EN     = 6;
    localparam int SQ_THIRD_EN  = 7;
    localparam int RT_TEST_LO   = 0;
    localparam int RT_PATH_LO   = 4;
    localparam int RT_BYPASS_LO = 8;
    localparam int AG_GAIN_LO   = 0;
    localparam int AG_UNITY     = 4;
    localparam int AG_SEL_UNI   = 5;
    localparam int AG_ANA_IN    = 6;
    localparam int AG_ADC_EN_LO = 7;
    localparam int AG_CAL_FAST  = 11;
    localparam int NIB_W        = 4;
    localparam int DAC_W        = 8;
    localparam int CAL_HIGH_W   = 9;
    localparam int CAL_W        = 33;

    // =========================================
    // timing, in core ticks unless noted
    localparam int CORE_DIV_W = 2;
    localparam logic [CORE_DIV_W-1:0] CORE_DIV_LAST = 2'h3;
    localparam int PHASE_W = 8;
    localparam logic [PHASE_W-1:0] FRAME_OH_TICKS = 8'h40;
    localparam logic [PHASE_W-1:0] ROW_OH_TICKS   = 8'h10;
    localparam logic [PHASE_W-1:0] KERNELS        = 8'hA0;
    localparam int LINE_W = 12;
    localparam logic [LINE_W-1:0] LINE_START     = 12'h001;
    localparam logic [LINE_W-1:0] LINE_START_SUB = 12'h002;
    localparam logic [LINE_W-1:0] LINE_STEP      = 12'h001;
    localparam logic [LINE_W-1:0] LINE_STEP_SUB  = 12'h002;
    // pulse length in sys clocks: mult*(step*(gran+1)+1)
    localparam logic [PHASE_W-1:0] PULSE_MULT = 8'h04;
    localparam logic [PHASE_W-1:0] PULSE_STEP = 8'h0C;

    typedef enum logic [1:0] {
        SCSR_FRAME_OH,
        SCSR_ROW_OH,
        SCSR_KERN
    } scsr_seq_t;
endpackage

// >>> rtl/scsr_shift_in.sv
`timescale 1ns/1ps
`default_nettype none
module scsr_shift_in
    import scsr_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // serial pins
    input  wire logic                      ser_clk,
    input  wire logic                      ser_data,
    input  wire logic                      ser_load,
    // decoded word
    output logic                           word_valid,
    output logic [scsr_pkg::ADDR_W-1:0]    word_addr,
    output logic [scsr_pkg::DATA_W-1:0]    word_data
);
    import scsr_pkg::*;

    logic [WORD_W-1:0]   shift_r, shift_nxt;
    logic [BITCNT_W-1:0] cnt_r, cnt_nxt;
    logic                clk_d_r, load_d_r;
    logic                valid_r, valid_nxt;
    logic [WORD_W-1:0]   word_r, word_nxt;

    // =========================================
    // shift and load
    always_comb
    begin
        shift_nxt = shift_r;
        cnt_nxt   = cnt_r;
        valid_nxt = 1'b0;
        word_nxt  = word_r;
        if (ser_clk && !clk_d_r)
        begin
            shift_nxt = {shift_r[WORD_W-2:0], ser_data}; // see [R15]
            if (cnt_r != WORD_BITS)
                cnt_nxt = cnt_r + 5'h01;
        end
        // a load before the word is complete is dropped
        if (ser_load && !load_d_r)
        begin
            cnt_nxt = '0;
            if (cnt_r == WORD_BITS) // see [R16]
            begin
                valid_nxt = 1'b1;
                word_nxt  = shift_r;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            shift_r  <= '0;
            cnt_r    <= '0;
            clk_d_r  <= 1'b0;
            load_d_r <= 1'b0;
            valid_r  <= 1'b0;
            word_r   <= '0;
        end
        else
        begin
            shift_r  <= shift_nxt;
            cnt_r    <= cnt_nxt;
            clk_d_r  <= ser_clk;
            load_d_r <= ser_load;
            valid_r  <= valid_nxt;
            word_r   <= word_nxt;
        end
    end

    assign word_valid = valid_r;
    assign word_addr  = word_r[WORD_W-1:DATA_W];
    assign word_data  = word_r[DATA_W-1:0];
endmodule
`default_nettype wire

// >>> rtl/scsr_top.sv
// What this block does
// [R1] second-slope reset at its timer line
// [R2] third-slope reset at its timer line
// [R3] charge transfer at its line, ending integration
// [R4] dac code zero is highest output
// [R5] test path select, default none
// [R6] normal path select, default all
// [R7] mux bypass default zero keeps mux
// [R8] four-bit gain, sixteen rising steps
// [R9] unity bit overrides gain, default set
// [R10] pre-attenuation half gain when zero
// [R11] external analog input when bit set
// [R12] per-converter enable, default all on
// [R13] calibration speed slow or fast
// [R14] calibration word over addresses 13-15
// [R15] sixteen-bit word, address over data
// [R16] load only after full word shifted
// [R17] controller shift clock at most 20 MHz
// [R18] reset defaults allow full readout
// [R19] frame overhead, then rows of kernels
// [R20] integration overlaps previous frame readout
// [R21] master internal timing, slave follows pins
// [R22] core clock is input divided by four
// [R23] line counter restarts at one, or at two when subsampling
// [R24] controller writes only during frame overhead; the block does not gate writes, and a mid-frame write takes effect at once
// [R25] second slope only when enabled, in master mode
// [R26] write touches only the addressed register
`timescale 1ns/1ps
`default_nettype none
module scsr_top
    import scsr_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // serial configuration port
    input  wire logic                       ser_clk,
    input  wire logic                       ser_data,
    input  wire logic                       ser_load,
    // integration pins, active low inputs in slave mode
    input  wire logic [2:0]                 int_time_in,
    output logic [2:0]                      int_time_out,
    output logic [2:0]                      int_time_oe,
    // timing
    output logic                            core_clk,
    output logic                            frame_valid,
    output logic                            line_valid,
    output logic                            charge_xfer_pulse,
    output logic                            second_slope_pulse,
    output logic                            third_slope_pulse,
    // analog controls
    output logic [scsr_pkg::DAC_W-1:0]      cal_dac_level,
    output logic [scsr_pkg::DAC_W-1:0]      black_dac_level,
    output logic [scsr_pkg::DAC_W-1:0]      offset_dac_level,
    output logic [scsr_pkg::NIB_W-1:0]      adc_test_path,
    output logic [scsr_pkg::NIB_W-1:0]      adc_norm_path,
    output logic [scsr_pkg::NIB_W-1:0]      mux_bypass,
    output logic [scsr_pkg::NIB_W-1:0]      amp_gain_step,
    output logic                            amp_unity,
    output logic                            amp_half_gain,
    output logic                            amp_ext_input,
    output logic [scsr_pkg::NIB_W-1:0]      adc_enable,
    output logic                            calib_fast,
    output logic [scsr_pkg::CAL_W-1:0]      calib_word
);
    import scsr_pkg::*;

    logic              wv;
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;

    // [R17] is the controller's to keep; edges are sampled at 250 MHz
    scsr_shift_in u_shift (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .ser_clk    (ser_clk),
        .ser_data   (ser_data),
        .ser_load   (ser_load),
        .word_valid (wv),
        .word_addr  (wa),
        .word_data  (wd)
    );

    // =========================================
    // register bank
    logic [DATA_W-1:0] bank_r   [NUM_REGS];
    logic [DATA_W-1:0] bank_nxt [NUM_REGS];

    // no frame-valid guard on writes: a write mid-frame takes effect at once
    for (genvar g = 0; g < NUM_REGS; g++)
    begin : g_bank
        always_comb
        begin
            bank_nxt[g] = bank_r[g];
            if (wv && wa == ADDR_W'(g)) // see [R26]
                bank_nxt[g] = wd;
        end

        always_ff @(posedge clk_sys or posedge rst)
        begin
            if (rst)
                bank_r[g] <= REG_DEFAULT[g]; // see [R18]
            else
                bank_r[g] <= bank_nxt[g];
        end
    end

    logic [DATA_W-1:0] sq, rt, ag;
    logic              master, subsample;
    logic [1:0]        gran;
    assign sq        = bank_r[A_SEQUENCER];
    assign rt        = bank_r[A_INPUT_ROUTING];
    assign ag        = bank_r[A_AMP_GAIN];
    assign master    = sq[SQ_MASTER];
    assign subsample = sq[SQ_SUBSAMPLE];
    assign gran      = sq[SQ_GRAN_LO +: 2];

    // =========================================
    // analog control outputs
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cal_dac_level    <= '0;
            black_dac_level  <= '0;
            offset_dac_level <= '0;
            adc_test_path    <= '0;
            adc_norm_path    <= '0;
            mux_bypass       <= '0;
            amp_gain_step    <= '0;
            amp_unity        <= 1'b0;
            amp_half_gain    <= 1'b0;
            amp_ext_input    <= 1'b0;
            adc_enable       <= '0;
            calib_fast       <= 1'b0;
            calib_word       <= '0;
        end
        else
        begin
            // level rises as the code falls: zero is full scale
            cal_dac_level    <= ~bank_r[A_CAL_DAC][DAC_W-1:0]; // see [R4]
            black_dac_level  <= ~bank_r[A_BLACK_DAC][DAC_W-1:0]; // see [R4]
            offset_dac_level <= ~bank_r[A_OFFSET_DAC][DAC_W-1:0]; // see [R4]
            adc_test_path    <= rt[RT_TEST_LO +: NIB_W]; // see [R5]
            adc_norm_path    <= rt[RT_PATH_LO +: NIB_W]; // see [R6]
            mux_bypass       <= rt[RT_BYPASS_LO +: NIB_W]; // see [R7]
            amp_unity        <= ag[AG_UNITY]; // see [R9]
            // gain step forced to zero while unity overrides it
            amp_gain_step    <= ag[AG_UNITY] ? '0
                                : ag[AG_GAIN_LO +: NIB_W]; // see [R8]
            amp_half_gain    <= ~ag[AG_SEL_UNI]; // see [R10]
            amp_ext_input    <= ag[AG_ANA_IN]; // see [R11]
            adc_enable       <= ag[AG_ADC_EN_LO +: NIB_W]; // see [R12]
            calib_fast       <= ag[AG_CAL_FAST]; // see [R13]
            calib_word       <= {bank_r[A_CALIB_HIGH][CAL_HIGH_W-1:0],
                                 bank_r[A_CALIB_MID],
                                 bank_r[A_CALIB_LOW]}; // see [R14]
        end
    end

    // =========================================
    // core clock divider
    logic [CORE_DIV_W-1:0] div_r, div_nxt;
    logic                  tick;
    assign tick    = (div_r == CORE_DIV_LAST); // see [R22]
    assign div_nxt = div_r + 2'h1;

    // =========================================
    // sequencer
    scsr_seq_t          st_r, st_nxt;
    logic [PHASE_W-1:0] ph_r, ph_nxt;
    logic [LINE_W-1:0]  line_r, line_nxt;
    logic [2:0]         trig;
    logic [2:0]         pins_d_r;
    logic [2:0]         integ_r, integ_nxt;
    logic               line_end, slave_ft;
    logic [LINE_W-1:0]  l_start, l_step;

    assign l_start  = subsample ? LINE_START_SUB : LINE_START;
    assign l_step   = subsample ? LINE_STEP_SUB : LINE_STEP;
    assign line_end = tick && st_r == SCSR_KERN && ph_r == KERNELS - 8'h01;
    // all three pins low together start the transfer
    assign slave_ft = ~|int_time_in && |pins_d_r;

    always_comb
    begin
        st_nxt   = st_r;
        ph_nxt   = ph_r;
        line_nxt = line_r;
        trig     = '0;
        if (master) // see [R21]
        begin
            trig[0] = line_end && line_r == bank_r[A_CHARGE_XFER]; // see [R3]
            trig[1] = line_end && sq[SQ_SS_EN]
                      && line_r == bank_r[A_SECOND_SLOPE]; // see [R1] [R25]
            trig[2] = line_end && sq[SQ_THIRD_EN]
                      && line_r == bank_r[A_THIRD_SLOPE]; // see [R2]
        end
        else
        begin
            trig[0] = slave_ft; // see [R21]
            trig[1] = !int_time_in[1] && pins_d_r[1] && int_time_in[0];
            trig[2] = !int_time_in[2] && pins_d_r[2] && int_time_in[0];
        end
        if (trig[0])
        begin
            st_nxt = SCSR_FRAME_OH;
            ph_nxt = '0;
        end
        else if (tick)
        begin
            ph_nxt = ph_r + 8'h01;
            case (st_r)
                SCSR_FRAME_OH:
                    if (ph_r == FRAME_OH_TICKS - 8'h01) // see [R19]
                    begin
                        st_nxt   = SCSR_ROW_OH;
                        ph_nxt   = '0;
                        line_nxt = l_start; // see [R23]
                    end
                SCSR_ROW_OH:
                    if (ph_r == ROW_OH_TICKS - 8'h01)
                    begin
                        st_nxt = SCSR_KERN;
                        ph_nxt = '0;
                    end
                SCSR_KERN:
                    if (ph_r == KERNELS - 8'h01) // see [R19]
                    begin
                        st_nxt   = SCSR_ROW_OH;
                        ph_nxt   = '0;
                        line_nxt = line_r + l_step;
                    end
                default:
                begin
                    st_nxt = SCSR_FRAME_OH;
                    ph_nxt = '0;
                end
            endcase
        end
    end

    // integration flags run beside readout of the previous frame
    always_comb
    begin
        integ_nxt = integ_r;
        // clear first: a slope reset on the transfer line still sets
        if (trig[0])
            integ_nxt = '0; // see [R3]
        if (st_r == SCSR_FRAME_OH && st_nxt == SCSR_ROW_OH)
            integ_nxt[0] = 1'b1; // see [R20]
        if (trig[1])
            integ_nxt[1] = 1'b1;
        if (trig[2])
            integ_nxt[2] = 1'b1;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            div_r    <= '0;
            st_r     <= SCSR_FRAME_OH;
            ph_r     <= '0;
            line_r   <= LINE_START;
            pins_d_r <= 3'h7;
            integ_r  <= '0;
        end
        else
        begin
            div_r    <= div_nxt;
            st_r     <= st_nxt;
            ph_r     <= ph_nxt;
            line_r   <= line_nxt;
            pins_d_r <= int_time_in;
            integ_r  <= integ_nxt;
        end
    end

    // =========================================
    // pulse stretchers, one per event
    logic [PHASE_W-1:0] plen;
    logic [2:0]         pulse_on;
    assign plen = PULSE_MULT * (PULSE_STEP * (PHASE_W'(gran) + 8'h01)
                  + 8'h01);

    for (genvar p = 0; p < 3; p++)
    begin : g_pulse
        logic [PHASE_W-1:0] pc_r, pc_nxt;
        always_comb
        begin
            pc_nxt = pc_r;
            if (trig[p])
                pc_nxt = plen;
            else if (pc_r != '0)
                pc_nxt = pc_r - 8'h01;
        end

        always_ff @(posedge clk_sys or posedge rst)
        begin
            if (rst)
                pc_r <= '0;
            else
                pc_r <= pc_nxt;
        end
        assign pulse_on[p] = (pc_nxt != '0);
    end

    // =========================================
    // registered outputs
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            core_clk           <= 1'b0;
            frame_valid        <= 1'b0;
            line_valid         <= 1'b0;
            charge_xfer_pulse  <= 1'b0;
            second_slope_pulse <= 1'b0;
            third_slope_pulse  <= 1'b0;
            int_time_out       <= '0;
            int_time_oe        <= '0;
        end
        else
        begin
            core_clk           <= div_nxt[CORE_DIV_W-1]; // see [R22]
            frame_valid        <= (st_nxt != SCSR_FRAME_OH); // see [R19]
            line_valid         <= (st_nxt == SCSR_KERN);
            charge_xfer_pulse  <= pulse_on[0];
            second_slope_pulse <= pulse_on[1];
            third_slope_pulse  <= pulse_on[2];
            int_time_out       <= integ_nxt;
            int_time_oe        <= {3{master}}; // see [R21]
        end
    end

    // =========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_core_tick_period: assert property (tick |=> !tick [*3] ##1 tick) // see [R22]
        else $error("core tick not every fourth clock");
    a_write_lands: assert property (wv |=> bank_r[$past(wa)] == $past(wd)) // see [R16]
        else $error("loaded word not stored");
    a_other_regs_kept: assert property (wv && wa != A_AMP_GAIN
        |=> $stable(bank_r[A_AMP_GAIN])) // see [R26]
        else $error("unaddressed register changed");
    a_line_restart: assert property (st_r == SCSR_FRAME_OH
        && st_nxt == SCSR_ROW_OH |=> line_r == l_start) // see [R23]
        else $error("line counter did not restart");
    a_xfer_at_line: assert property (master && line_end
        && line_r == bank_r[A_CHARGE_XFER]
        |=> st_r == SCSR_FRAME_OH) // see [R3]
        else $error("transfer not started at its line");
    a_slope_enable: assert property (master && !sq[SQ_SS_EN]
        |-> !trig[1]) // see [R25]
        else $error("second slope without enable");
    a_slope_pos: assert property (master && trig[1]
        |-> line_r == bank_r[A_SECOND_SLOPE]) // see [R1]
        else $error("second slope at wrong line");
    a_third_pos: assert property (master && trig[2]
        |-> sq[SQ_THIRD_EN] && line_r == bank_r[A_THIRD_SLOPE]) // see [R2]
        else $error("third slope at wrong line");
    a_fv_overhead: assert property (trig[0] |=> ##1 !frame_valid) // see [R19]
        else $error("frame valid high in overhead");
    a_unity_gain: assert property (ag[AG_UNITY] |=> amp_gain_step == '0) // see [R9]
        else $error("gain applied under unity");
    a_dac_map: assert property ($past(bank_r[A_CAL_DAC][DAC_W-1:0]) == '0
        |-> cal_dac_level == '1) // see [R4]
        else $error("dac code zero not highest");

    c_write: cover property (wv);
    c_line_done: cover property (line_end);
    c_xfer: cover property (trig[0]);
    c_slave_ft: cover property (!master && slave_ft);
endmodule
`default_nettype wire

// >>> rtl/scsr_top_fix.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> sim/scsr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module scsr_ctrl_model
(
    // clock
    input  wire logic clk_sys,
    // serial port toward the device
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_load
);
    initial
    begin
        ser_clk  = 1'b0;
        ser_data = 1'b0;
        ser_load = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // =========================================
    // one word, msb first; short cuts the word after 8 bits
    task automatic send(input logic [15:0] w, input logic full);
        int nb;
        nb = full ? 16 : 8;
        for (int i = 0; i < nb; i++)
        begin
            ser_data = w[15-i];
            hold(7);
            // 7 clocks per half period keeps the shift clock below 20 MHz
            ser_clk = 1'b1;
            hold(7);
            ser_clk = 1'b0;
        end
        // data line no longer held: show the inverse, not the last bit
        ser_data = ~ser_data;
        ser_load = 1'b1;
        hold(3);
        ser_load = 1'b0;
        hold(2);
    endtask
endmodule
`default_nettype wire

// >>> sim/sensor_config_serial_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_config_serial_regs_test;
    import scsr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst     = 1'b1;
    logic ser_clk, ser_data, ser_load, core_clk, frame_valid, line_valid;
    logic [2:0]  int_time_in = 3'h7;
    logic [2:0]  int_time_oe, int_out;
    logic        xfer_p, ss_p, ts_p;
    logic [7:0]  cal_dac, black_dac, offset_dac;
    logic [3:0]  tpath, npath, bypass, gain, adc_en;
    logic        unity, half_gain, ext_in, cal_fast;
    logic [32:0] cal_word;
    logic [80:0] got, e;
    logic [11:0] exp_r [16];
    logic [31:0] seed = 32'h0000B861;
    int          err_total = 0;
    int          checked   = 0;
    int          cyc       = 0;
    int          n;

    always #2 clk_sys = ~clk_sys;

    scsr_top u_scsr_top (.clk_sys(clk_sys), .rst(rst), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_load(ser_load), .int_time_in(int_time_in),
        .int_time_out(int_out), .int_time_oe(int_time_oe),
        .core_clk(core_clk),
        .frame_valid(frame_valid), .line_valid(line_valid),
        .charge_xfer_pulse(xfer_p), .second_slope_pulse(ss_p),
        .third_slope_pulse(ts_p),
        .cal_dac_level(cal_dac), .black_dac_level(black_dac),
        .offset_dac_level(offset_dac), .adc_test_path(tpath),
        .adc_norm_path(npath), .mux_bypass(bypass), .amp_gain_step(gain),
        .amp_unity(unity), .amp_half_gain(half_gain),
        .amp_ext_input(ext_in), .adc_enable(adc_en),
        .calib_fast(cal_fast), .calib_word(cal_word));

    scsr_ctrl_model u_scsr_ctrl_model (.clk_sys(clk_sys), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_load(ser_load));

    assign got = {cal_dac, black_dac, offset_dac, tpath, npath, bypass, gain,
                  unity, half_gain, ext_in, adc_en, cal_fast, cal_word};

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input logic [80:0] s, input logic [80:0] x);
        checked++;
        if (s !== x)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask

    task automatic hold(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // a write waits for the start of the next frame overhead
    task automatic overhead_send(input logic [15:0] w, input logic full);
        while (frame_valid !== 1'b1)
            hold(1);
        while (frame_valid !== 1'b0)
            hold(1);
        u_scsr_ctrl_model.send(w, full);
    endtask

    // =========================================
    // expected outputs from the mirrored register contents
    task automatic check_all;
        e = {~exp_r[8][7:0], ~exp_r[9][7:0], ~exp_r[10][7:0],
             exp_r[11][3:0], exp_r[11][7:4], exp_r[11][11:8],
             exp_r[12][4] ? 4'h0 : exp_r[12][3:0], exp_r[12][4],
             ~exp_r[12][5], exp_r[12][6], exp_r[12][10:7], exp_r[12][11],
             exp_r[15][8:0], exp_r[14], exp_r[13]};
        chk(got[80:57], e[80:57]);
        chk(got[56:45], e[56:45]);
        chk(got[44:33], e[44:33]);
        chk(got[32:0], e[32:0]);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ceiling well above the ~50000 cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 70000)
        begin
            err_total++;
            report_and_stop;
        end
    end

    initial
    begin
        logic [3:0] a;
        for (int i = 0; i < 16; i++)
            exp_r[i] = REG_DEFAULT[i];
        hold(4);
        rst = 1'b0;
        hold(1);
        check_all;
        chk(81'(int_time_oe), 81'(3'h7));
        chk(81'(frame_valid), 81'h0);
        // two-line frames; the overhead after reset takes the first write
        u_scsr_ctrl_model.send({A_CHARGE_XFER, 12'h002}, 1'b1);
        exp_r[7] = 12'h002;
        // =====================================
        // core clock: 8 toggles in 16 system clocks
        n = 0;
        for (int i = 0; i < 16; i++)
        begin
            a[0] = core_clk;
            hold(1);
            if (core_clk !== a[0])
                n++;
        end
        chk(81'(n), 81'd8);
        // =====================================
        // first line after frame overhead: 160 kernels of 4 clocks
        n = 0;
        while (frame_valid !== 1'b1 && n < 600)
        begin
            hold(1);
            n++;
        end
        chk(81'(frame_valid), 81'h1);
        n = 0;
        while (line_valid !== 1'b1 && n < 300)
        begin
            hold(1);
            n++;
        end
        n = 0;
        while (line_valid === 1'b1 && n < 1000)
        begin
            hold(1);
            n++;
        end
        chk(81'(n), 81'd640);
        chk(81'(int_out[0]), 81'h1);
        // line two ends the frame: transfer pulse, integration over
        while (frame_valid !== 1'b0)
            hold(1);
        chk(81'(int_out[0]), 81'h0);
        n = 0;
        while (xfer_p === 1'b1)
        begin
            hold(1);
            n++;
        end
        chk(81'(n), 81'(4 * (12 * (2 + 1) + 1)));
        // both slope resets at the end of line one once enabled
        overhead_send({A_SECOND_SLOPE, 12'h001}, 1'b1);
        overhead_send({A_THIRD_SLOPE, 12'h001}, 1'b1);
        overhead_send({A_SEQUENCER, 12'h0E9}, 1'b1);
        while (ss_p !== 1'b1)
            hold(1);
        chk(81'({ts_p, int_out[2:1]}), 81'h7);
        n = 0;
        while (ss_p === 1'b1)
        begin
            hold(1);
            n++;
        end
        chk(81'(n), 81'(4 * (12 * (2 + 1) + 1)));
        // =====================================
        // random writes; the first three hit the calibration word
        for (int k = 0; k < 24; k++)
        begin
            seed = xs(seed);
            a = (k < 3) ? 4'(13 + k) : 4'(8 + seed[19:16] % 8);
            overhead_send({a, seed[11:0]}, 1'b1);
            exp_r[a] = seed[11:0];
            hold(2);
            check_all;
        end
        // a short word must be dropped, the next full one taken
        overhead_send({A_CAL_DAC, 12'h0F0}, 1'b0);
        hold(2);
        check_all;
        overhead_send({A_BLACK_DAC, 12'h03C}, 1'b1);
        exp_r[9] = 12'h03C;
        hold(2);
        check_all;
        report_and_stop;
    end
endmodule
`default_nettype wire
